// >>> dv/tb.sv
/*
 * self-checking bench for the enhanced configuration block.
 * assumes the host model drives the register bus; the bench drives the rest.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rv, c2, lo, hi, f, t, int_en, fifo_ctl, modem_ctl;
    logic wr, rd, tx_ok, rts, hit, sleep;
    logic [3:0] sel_n = 4'hF, tmo = 4'h0, swm;
    logic [6:0] fill = 7'h00, ftx = 7'h00, frx = 7'h00, tx_trig, rx_trig;
    logic [27:0] txf = '0, rxf = '0, txt = '0, rxt = '0, r;
    logic cv = 1'b0, clr = 1'b0, cts = 1'b0, pend = 1'b0;
    logic [7:0] ch = 8'h00;
    logic [15:0] baud;
    logic [6:0] lv [4] = '{7'h07, 7'h08, 7'h05, 7'h04};
    integer seed = 39242;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    always #5 clk_i = ~clk_i;
    uefc_host_model h (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    uefc_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .port_sel_n_i(sel_n), .rdata_o(rdata), .rx_fill_i(fill), .tx_free_all_i(txf), .rx_fill_all_i(rxf),
        .tx_trig_all_i(txt), .rx_trig_all_i(rxt), .rx_timeout_all_i(tmo), .fb_tx_level_i(ftx),
        .fb_rx_level_i(frx), .rx_char_valid_i(cv), .rx_char_i(ch), .ident_clear_i(clr), .cts_i(cts),
        .tx_char_pending_i(pend), .tx_start_ok_o(tx_ok), .rts_o(rts), .special_hit_o(hit), .baud_divisor_o(baud),
        .sw_flow_mode_o(swm), .sleep_en_o(sleep), .int_en_o(int_en), .fifo_ctl_o(fifo_ctl),
        .modem_ctl_o(modem_ctl), .tx_trig_o(tx_trig), .rx_trig_o(rx_trig));
    // ==========================================================
    // checking and closing
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] rdy_exp();
        logic [7:0] e;
        for (int p = 0; p < 4; p++) begin
            e[p] = txf[p*7+:7] >= txt[p*7+:7];
            e[p+4] = (rxf[p*7+:7] > rxt[p*7+:7]) | tmo[p];
        end
        return e;
    endfunction
    // the run needs under two hundred cycles; this only cuts a hang
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk("divisor_rst", baud, 16'h0001);
        h.wr(3'h3, 8'h00);
        h.wr(3'h1, 8'hFF);
        h.wr(3'h4, 8'hE0);
        h.wr(3'h2, 8'hFF);
        @(negedge clk_i);
        chk("int_en_locked", int_en, 8'h0F);
        chk("modem_locked", modem_ctl, 8'h00);
        chk("fifo_locked", fifo_ctl, 8'hCF);
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        h.div_load(lo, hi);
        chk("divisor", baud, {hi, lo});
        $display("test protect and divisor done");
        f = 8'h10 | (8'($random(seed)) & 8'h0F);
        c2 = 8'($random(seed));
        h.wr(3'h3, 8'hBF);
        h.wr(3'h2, f);
        h.wr(3'h7, c2);
        h.rd(3'h2, rv);
        chk("feature", rv, f);
        chk("sw_flow", swm, f[3:0]);
        h.wr(3'h3, 8'h00);
        h.wr(3'h1, 8'hF0);
        h.wr(3'h4, 8'h40);
        h.wr(3'h2, 8'h30);
        @(negedge clk_i);
        chk("int_en_open", int_en, 8'hF0);
        chk("fifo_open", fifo_ctl, 8'h30);
        chk("sleep", sleep, 1'b1);
        h.div_load(~lo, ~hi);
        chk("divisor_sleep", baud, {hi, lo});
        $display("test feature page and sleep done");
        ftx <= 7'($random(seed));
        frx <= 7'($random(seed));
        t = {1'b1, 3'($random(seed)), 1'b1, 3'($random(seed))};
        h.wr(3'h6, 8'h12);
        h.wr(3'h7, t);
        @(negedge clk_i);
        chk("tx_trig", tx_trig, {t[3:0], 2'b00});
        chk("rx_trig", rx_trig, {t[7:4], 2'b00});
        h.wr(3'h7, {4'h0, t[3:0]});
        @(negedge clk_i);
        chk("rx_fallback", rx_trig, frx);
        h.wr(3'h7, {t[7:4], 4'h0});
        @(negedge clk_i);
        chk("tx_fallback", tx_trig, ftx);
        chk("rx_kept", rx_trig, {t[7:4], 2'b00});
        h.wr(3'h7, {4'h0, t[3:0]});
        h.wr(3'h3, 8'hBF);
        h.wr(3'h2, 8'hE0);
        h.wr(3'h3, 8'h00);
        h.wr(3'h7, 8'h55);
        h.wr(3'h6, 8'hFF);
        h.wr(3'h1, 8'h00);
        h.wr(3'h4, 8'h04);
        h.wr(3'h2, 8'h00);
        @(negedge clk_i);
        chk("trig_locked", rx_trig, frx);
        chk("trig_locked_tx", tx_trig, {t[3:0], 2'b00});
        chk("int_en_kept", int_en, 8'hF0);
        chk("modem_kept", modem_ctl, 8'h44);
        chk("fifo_kept", fifo_ctl, 8'h30);
        $display("test thresholds and triggers done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            fill <= lv[i];
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk("rts", rts, 4'h6 >> i & 4'h1);
        end
        @(posedge clk_i);
        pend <= 1'b1;
        cts <= 1'b1;
        @(negedge clk_i);
        chk("cts_stop", tx_ok, 1'b0);
        @(posedge clk_i);
        cts <= 1'b0;
        @(negedge clk_i);
        chk("cts_go", tx_ok, 1'b1);
        // last pass raises a match and a clear together: the set must win
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            ch <= (i == 0) ? ~c2 : c2;
            cv <= (i != 2);
            clr <= (i >= 2);
            @(posedge clk_i);
            cv <= 1'b0;
            clr <= 1'b0;
            @(negedge clk_i);
            chk("special", hit, i == 1 || i == 3);
        end
        $display("test flow control and special done");
        for (int i = 0; i < 5; i++) begin
            r = 28'($random(seed));
            @(posedge clk_i);
            txf <= r;
            rxf <= r;
            txt <= (i == 0) ? r : 28'($random(seed));
            rxt <= (i == 0) ? r : 28'($random(seed));
            tmo <= (i == 0) ? 4'h0 : 4'($random(seed));
            sel_n <= 4'($random(seed)) & 4'h7;
            h.rd(3'h7, rv);
            chk("ready", rv, rdy_exp());
        end
        h.wr(3'h4, 8'h54);
        h.rd(3'h7, rv);
        chk("ready_loop", rv, 8'h00);
        $display("test ready status done");
        summarize();
    end
endmodule
`default_nettype wire

// >>> dv/uefc_host_model.sv
/*
 * host processor model: byte writes and reads on the parallel register bus.
 * assumes one clock shared with the block; the bench calls the tasks.
 */
`timescale 1ns/1ps
`default_nettype none
module uefc_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [2:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // ==========================================================
    // bus cycles
    initial begin
        addr_o = 3'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // data is scrambled after the strobe so a late capture shows up
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask
    // ==========================================================
    // divisor page: line control 80, both latches, then back to 00
    task automatic div_load(input logic [7:0] lo, input logic [7:0] hi);
        wr(3'h3, 8'h80);
        wr(3'h0, lo);
        wr(3'h1, hi);
        wr(3'h3, 8'h00);
    endtask
endmodule
`default_nettype wire

// >>> hw/uefc_core.sv
/*
 * enhanced configuration of one uart channel: feature register, protected
 * bits, divisor latches, flow thresholds, trigger levels, fifo ready status,
 * auto rts/cts and special character detect.
 * assumes fifo levels of all four ports and the rx character stream come
 * from the surrounding channel logic, synchronous to clk_i.
 */
// Behaviour
// - low four feature bits select the software flow control combination.
// - protected interrupt enable, fifo and modem control bits change only with feature bit 4.
// - special detect compares rx char with pause char two, sets ident bit 4.
// - auto rts goes high at halt level, low again at restore level.
// - auto cts stops new characters while cts input is high.
// - baud divisor is sixteen bits, high latch msb, low latch lsb.
// - divisor latches writable only while sleep mode is off.
// - threshold register holds halt in 3:0, restore in 7:4, steps of four.
// - threshold writes need feature bit 4 and modem bit 6 set.
// - trigger register holds tx level in 3:0, rx level in 7:4, n times four.
// - trigger level writes need feature bit 4 and modem bit 6 set.
// - zero trigger field falls back to fifo control selected level.
// - ready bits 3:0 show tx free space at least tx trigger per port.
// - ready bits 7:4 show rx fill above rx trigger or timeout per port.
// - ready register read-only at 111 with select low, modem bit 2, no loopback.
// - line control bf maps feature at 02 and flow characters at 04..07.
// - modem bit 6 swaps threshold and trigger registers into 06 and 07.
// - modem bit 2 switches the fifo ready register into the map.
// - interrupt enable bit 4 turns sleep mode on and off.
`timescale 1ns/1ps
`default_nettype none
module uefc_core #(
    parameter int PORTS = 4,
    parameter int LEVEL_W = 7
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [PORTS-1:0] port_sel_n_i,
    output logic [7:0] rdata_o,
    input wire logic [LEVEL_W-1:0] rx_fill_i,
    input wire logic [PORTS*LEVEL_W-1:0] tx_free_all_i,
    input wire logic [PORTS*LEVEL_W-1:0] rx_fill_all_i,
    input wire logic [PORTS*LEVEL_W-1:0] tx_trig_all_i,
    input wire logic [PORTS*LEVEL_W-1:0] rx_trig_all_i,
    input wire logic [PORTS-1:0] rx_timeout_all_i,
    input wire logic [LEVEL_W-1:0] fb_tx_level_i,
    input wire logic [LEVEL_W-1:0] fb_rx_level_i,
    input wire logic rx_char_valid_i,
    input wire logic [7:0] rx_char_i,
    input wire logic ident_clear_i,
    input wire logic cts_i,
    input wire logic tx_char_pending_i,
    output logic tx_start_ok_o,
    output logic rts_o,
    output logic special_hit_o,
    output logic [15:0] baud_divisor_o,
    output logic [3:0] sw_flow_mode_o,
    output logic sleep_en_o,
    output logic [7:0] int_en_o,
    output logic [7:0] fifo_ctl_o,
    output logic [7:0] modem_ctl_o,
    output logic [LEVEL_W-1:0] tx_trig_o,
    output logic [LEVEL_W-1:0] rx_trig_o
);
    initial begin
        if (PORTS != 4 || LEVEL_W < 7) begin
            $error("uefc_core needs four ports and levels of at least 7 bits");
        end
    end

    // ==========================================================
    // registers
    logic [7:0] line_control_reg;
    logic [7:0] feature_enable_control_reg;
    logic [7:0] int_en_reg, fifo_ctl_reg, modem_ctl_reg;
    logic [7:0] baud_divisor_low_reg, baud_divisor_high_reg;
    logic [7:0] resume_char_one_reg, resume_char_two_reg;
    logic [7:0] pause_char_one_reg, pause_char_two_reg;
    logic [7:0] flow_threshold_reg, fifo_trigger_level_reg;
    logic special_hit_reg;
    logic rts_reg;
    logic [7:0] rdata_reg;

    // ==========================================================
    // decode
    function automatic logic [LEVEL_W-1:0] nib_level(input logic [3:0] nib);
        nib_level = LEVEL_W'({nib, 2'b00});
    endfunction

    logic page_feature, page_div, enh_en, alt_page, ready_page;
    assign page_feature = (line_control_reg == uefc_pkg::PAGE_FEATURE_KEY);
    assign page_div = line_control_reg[uefc_pkg::DIV_PAGE_BIT] & ~page_feature;
    assign enh_en = feature_enable_control_reg[uefc_pkg::FEAT_ENH_BIT];
    assign alt_page = enh_en & modem_ctl_reg[uefc_pkg::MODEM_ALT_BIT] & ~page_feature;
    assign ready_page = ~(&port_sel_n_i) & modem_ctl_reg[uefc_pkg::MODEM_READY_BIT]
                        & ~modem_ctl_reg[uefc_pkg::MODEM_LOOP_BIT];

    logic wr_div_low, wr_div_high, wr_feature, wr_thresh, wr_trig, wr_int_en, wr_modem_ctl, wr_fifo_ctl;
    assign wr_div_low = wr_i & page_div & (addr_i == uefc_pkg::ADDR_DIV_LOW)
                        & ~int_en_reg[uefc_pkg::INT_EN_SLEEP_BIT];
    assign wr_div_high = wr_i & page_div & (addr_i == uefc_pkg::ADDR_DIV_HIGH)
                         & ~int_en_reg[uefc_pkg::INT_EN_SLEEP_BIT];
    assign wr_feature = wr_i & page_feature & (addr_i == uefc_pkg::ADDR_FEATURE);
    assign wr_thresh = wr_i & alt_page & (addr_i == uefc_pkg::ADDR_THRESHOLD);
    assign wr_trig = wr_i & alt_page & (addr_i == uefc_pkg::ADDR_TRIGGER);
    assign wr_int_en = wr_i & ~page_div & ~page_feature & (addr_i == uefc_pkg::ADDR_INT_EN);
    assign wr_fifo_ctl = wr_i & ~page_div & ~page_feature & (addr_i == uefc_pkg::ADDR_FIFO_CTL);
    assign wr_modem_ctl = wr_i & ~page_feature & (addr_i == uefc_pkg::ADDR_MODEM_CTRL);

    // protected bits keep old value unless the enhanced enable is set
    function automatic logic [7:0] guard(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask, input logic en);
        guard = en ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction

    // ==========================================================
    // line control and feature
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_control_reg <= uefc_pkg::REG_RESET;
        end else if (wr_i && addr_i == uefc_pkg::ADDR_LINE_CTRL) begin
            line_control_reg <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            feature_enable_control_reg <= uefc_pkg::REG_RESET;
        end else if (wr_feature) begin
            feature_enable_control_reg <= wdata_i;
        end
    end

    // ==========================================================
    // protected interrupt enable, fifo control, modem control
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            int_en_reg <= uefc_pkg::REG_RESET;
            fifo_ctl_reg <= uefc_pkg::REG_RESET;
            modem_ctl_reg <= uefc_pkg::REG_RESET;
        end else begin
            if (wr_int_en) begin
                int_en_reg <= guard(int_en_reg, wdata_i, uefc_pkg::INT_EN_PROT_MASK, enh_en);
            end
            if (wr_fifo_ctl) begin
                fifo_ctl_reg <= guard(fifo_ctl_reg, wdata_i, uefc_pkg::FIFO_CTL_PROT_MASK, enh_en);
            end
            if (wr_modem_ctl) begin
                modem_ctl_reg <= guard(modem_ctl_reg, wdata_i, uefc_pkg::MODEM_PROT_MASK, enh_en);
            end
        end
    end

    // ==========================================================
    // divisor, flow characters, thresholds, triggers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            baud_divisor_low_reg <= uefc_pkg::DIV_RESET[7:0];
            baud_divisor_high_reg <= uefc_pkg::DIV_RESET[15:8];
        end else begin
            if (wr_div_low) begin
                baud_divisor_low_reg <= wdata_i;
            end
            if (wr_div_high) begin
                baud_divisor_high_reg <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            resume_char_one_reg <= uefc_pkg::REG_RESET;
            resume_char_two_reg <= uefc_pkg::REG_RESET;
            pause_char_one_reg <= uefc_pkg::REG_RESET;
            pause_char_two_reg <= uefc_pkg::REG_RESET;
        end else if (wr_i && page_feature) begin
            case (addr_i)
                uefc_pkg::ADDR_RESUME_ONE: resume_char_one_reg <= wdata_i;
                uefc_pkg::ADDR_RESUME_TWO: resume_char_two_reg <= wdata_i;
                uefc_pkg::ADDR_PAUSE_ONE: pause_char_one_reg <= wdata_i;
                uefc_pkg::ADDR_PAUSE_TWO: pause_char_two_reg <= wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flow_threshold_reg <= uefc_pkg::REG_RESET;
            fifo_trigger_level_reg <= uefc_pkg::REG_RESET;
        end else begin
            if (wr_thresh) begin
                flow_threshold_reg <= wdata_i;
            end
            if (wr_trig) begin
                fifo_trigger_level_reg <= wdata_i;
            end
        end
    end

    // ==========================================================
    // trigger selection and flow control
    logic [LEVEL_W-1:0] halt_level, restore_level;
    assign halt_level = nib_level(flow_threshold_reg[3:0]);
    assign restore_level = nib_level(flow_threshold_reg[7:4]);
    assign tx_trig_o = (fifo_trigger_level_reg[3:0] == 4'h0) ? fb_tx_level_i
                       : nib_level(fifo_trigger_level_reg[3:0]);
    assign rx_trig_o = (fifo_trigger_level_reg[7:4] == 4'h0) ? fb_rx_level_i
                       : nib_level(fifo_trigger_level_reg[7:4]);

    // rts held between thresholds gives hysteresis
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rts_reg <= 1'b0;
        end else if (!feature_enable_control_reg[uefc_pkg::FEAT_AUTO_RTS_BIT]) begin
            rts_reg <= 1'b0;
        end else if (rx_fill_i >= halt_level) begin
            rts_reg <= 1'b1;
        end else if (rx_fill_i <= restore_level) begin
            rts_reg <= 1'b0;
        end
    end
    assign rts_o = rts_reg;

    assign tx_start_ok_o = tx_char_pending_i
                           & ~(feature_enable_control_reg[uefc_pkg::FEAT_AUTO_CTS_BIT] & cts_i);

    // set beats clear in the same cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            special_hit_reg <= 1'b0;
        end else if (rx_char_valid_i && feature_enable_control_reg[uefc_pkg::FEAT_SPECIAL_BIT]
                     && rx_char_i == pause_char_two_reg) begin
            special_hit_reg <= 1'b1;
        end else if (ident_clear_i) begin
            special_hit_reg <= 1'b0;
        end
    end
    assign special_hit_o = special_hit_reg;

    // ==========================================================
    // fifo ready status
    logic [7:0] ready_status;
    genvar gi;
    generate
        for (gi = 0; gi < PORTS; gi++) begin : g_port
            uefc_thresh_cmp #(.LEVEL_W(LEVEL_W)) u_cmp (
                .tx_free_i(tx_free_all_i[gi*LEVEL_W +: LEVEL_W]),
                .tx_trig_i(tx_trig_all_i[gi*LEVEL_W +: LEVEL_W]),
                .rx_fill_i(rx_fill_all_i[gi*LEVEL_W +: LEVEL_W]),
                .rx_trig_i(rx_trig_all_i[gi*LEVEL_W +: LEVEL_W]),
                .rx_timeout_i(rx_timeout_all_i[gi]),
                .tx_ready_o(ready_status[gi]),
                .rx_ready_o(ready_status[gi+4])
            );
        end
    endgenerate

    // ==========================================================
    // read path
    logic [7:0] rd_value;
    always_comb begin
        rd_value = 8'h00;
        if (ready_page && addr_i == uefc_pkg::ADDR_READY) begin
            rd_value = ready_status;
        end else if (page_feature) begin
            case (addr_i)
                uefc_pkg::ADDR_FEATURE: rd_value = feature_enable_control_reg;
                uefc_pkg::ADDR_LINE_CTRL: rd_value = line_control_reg;
                uefc_pkg::ADDR_RESUME_ONE: rd_value = resume_char_one_reg;
                uefc_pkg::ADDR_RESUME_TWO: rd_value = resume_char_two_reg;
                uefc_pkg::ADDR_PAUSE_ONE: rd_value = pause_char_one_reg;
                uefc_pkg::ADDR_PAUSE_TWO: rd_value = pause_char_two_reg;
                default: rd_value = 8'h00;
            endcase
        end else if (page_div && addr_i == uefc_pkg::ADDR_DIV_LOW) begin
            rd_value = baud_divisor_low_reg;
        end else if (page_div && addr_i == uefc_pkg::ADDR_DIV_HIGH) begin
            rd_value = baud_divisor_high_reg;
        end else begin
            case (addr_i)
                uefc_pkg::ADDR_INT_EN: rd_value = int_en_reg;
                uefc_pkg::ADDR_LINE_CTRL: rd_value = line_control_reg;
                uefc_pkg::ADDR_MODEM_CTRL: rd_value = modem_ctl_reg;
                uefc_pkg::ADDR_THRESHOLD: rd_value = alt_page ? flow_threshold_reg : 8'h00;
                uefc_pkg::ADDR_TRIGGER: rd_value = alt_page ? fifo_trigger_level_reg : 8'h00;
                default: rd_value = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_i) begin
            rdata_reg <= rd_value;
        end
    end
    assign rdata_o = rdata_reg;

    assign baud_divisor_o = {baud_divisor_high_reg, baud_divisor_low_reg};
    assign sw_flow_mode_o = feature_enable_control_reg[uefc_pkg::FEAT_SWFLOW_MSB:0];
    assign sleep_en_o = int_en_reg[uefc_pkg::INT_EN_SLEEP_BIT];
    assign int_en_o = int_en_reg;
    assign fifo_ctl_o = fifo_ctl_reg;
    assign modem_ctl_o = modem_ctl_reg;

    // ==========================================================
    // checks
    chk_div_sleep_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $past(int_en_reg[4]) |-> $stable(baud_divisor_o))
        else $error("divisor changed during sleep");
    chk_int_en_protect: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !enh_en |=> $stable(int_en_reg[7:4]) && $stable(modem_ctl_reg[7:5]))
        else $error("protected bit changed without enable");
    chk_fifo_protect: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !enh_en |=> $stable(fifo_ctl_reg[5:4]))
        else $error("protected fifo bits changed");
    chk_thresh_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(enh_en && modem_ctl_reg[6]) |=> $stable(flow_threshold_reg))
        else $error("threshold written without access");
    chk_trig_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(enh_en && modem_ctl_reg[6]) |=> $stable(fifo_trigger_level_reg))
        else $error("trigger written without access");
    chk_rts_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        feature_enable_control_reg[6] && rx_fill_i >= halt_level |=> rts_o)
        else $error("rts not raised at halt");
    chk_cts_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        feature_enable_control_reg[7] && cts_i |-> !tx_start_ok_o)
        else $error("tx allowed while cts high");
    chk_special_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rx_char_valid_i && feature_enable_control_reg[5] && rx_char_i == pause_char_two_reg
        |=> special_hit_o)
        else $error("special char not flagged");
    chk_trig_fallback: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fifo_trigger_level_reg[7:4] == 4'h0 |-> rx_trig_o == fb_rx_level_i)
        else $error("rx trigger fallback wrong");
    chk_ready_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_i && ready_page && addr_i == 3'h7 |=> rdata_o == $past(ready_status))
        else $error("ready status not read");
endmodule
`default_nettype wire

// >>> hw/uefc_pkg.sv
/*
 * constants for the enhanced-configuration block of one uart channel:
 * register addresses, page keys, field positions and reset values.
 * assumes an 8-bit parallel host bus with a 3-bit register address.
 */
package uefc_pkg;
    // ==========================================================
    // register addresses (3-bit host address)
    localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
    localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
    localparam logic [2:0] ADDR_FIFO_CTL = 3'h2;
    localparam logic [2:0] ADDR_FEATURE = 3'h2;
    localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
    localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
    localparam logic [2:0] ADDR_RESUME_ONE = 3'h4;
    localparam logic [2:0] ADDR_RESUME_TWO = 3'h5;
    localparam logic [2:0] ADDR_PAUSE_ONE = 3'h6;
    localparam logic [2:0] ADDR_THRESHOLD = 3'h6;
    localparam logic [2:0] ADDR_PAUSE_TWO = 3'h7;
    localparam logic [2:0] ADDR_TRIGGER = 3'h7;
    localparam logic [2:0] ADDR_READY = 3'h7;
    localparam logic [2:0] ADDR_INT_EN = 3'h1;
    // ==========================================================
    // page keys written to line control
    localparam logic [7:0] PAGE_FEATURE_KEY = 8'hBF;
    localparam int DIV_PAGE_BIT = 7;
    // ==========================================================
    // field positions
    localparam int FEAT_SWFLOW_MSB = 3;
    localparam int FEAT_ENH_BIT = 4;
    localparam int FEAT_SPECIAL_BIT = 5;
    localparam int FEAT_AUTO_RTS_BIT = 6;
    localparam int FEAT_AUTO_CTS_BIT = 7;
    localparam int INT_EN_SLEEP_BIT = 4;
    localparam int MODEM_READY_BIT = 2;
    localparam int MODEM_LOOP_BIT = 4;
    localparam int MODEM_ALT_BIT = 6;
    localparam logic [7:0] INT_EN_PROT_MASK = 8'hF0;
    localparam logic [7:0] FIFO_CTL_PROT_MASK = 8'h30;
    localparam logic [7:0] MODEM_PROT_MASK = 8'hE0;
    localparam int LEVEL_STEP_SHIFT = 2;
    // ==========================================================
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0001;
endpackage

// >>> hw/uefc_thresh_cmp.sv
/*
 * one level comparator per port for the fifo ready status byte.
 * assumes fifo levels and triggers are already expanded to byte counts.
 */
`timescale 1ns/1ps
`default_nettype none
module uefc_thresh_cmp #(
    parameter int LEVEL_W = 7
) (
    input wire logic [LEVEL_W-1:0] tx_free_i,
    input wire logic [LEVEL_W-1:0] tx_trig_i,
    input wire logic [LEVEL_W-1:0] rx_fill_i,
    input wire logic [LEVEL_W-1:0] rx_trig_i,
    input wire logic rx_timeout_i,
    output logic tx_ready_o,
    output logic rx_ready_o
);
    // ==========================================================
    // compare
    assign tx_ready_o = (tx_free_i >= tx_trig_i);
    assign rx_ready_o = (rx_fill_i > rx_trig_i) | rx_timeout_i;
endmodule
`default_nettype wire
